// ---- i2c_stx_pkg.sv ----
// Constants and types for the buffered I2C slave transmitter
// Operation
// - Enter only on own address with read
// - Address acked: event flag, interrupt, code A8h
// - Addressed after lost arbitration: code B0h
// - Final-byte NACK bit has no effect here
// - With ack enable, send up to count
// - Full count acked by master: code B8h
// - Ack enable 0: send count, then unaddressed
// - Ack enable cleared mid-transfer: finish, code C8h
// - Unaddressed device releases data line: all ones
// - Ack enable 0: own address not acknowledged
// - Ack enable 1 restores own address recognition
// - Master NACK on a byte: code C0h
// - C0h/C8h with ack enable 0: ignore address
// - C0h/C8h with ack enable 1: recognise address
// - General call recognised while its enable set
// - Start request queued until bus free
// - Buffer pointer wraps to slot zero unprotected
// - Control write with flag 0 clears interrupt
package i2c_stx_pkg;

  localparam int unsigned BUF_DEPTH = 68;
  localparam int unsigned PTR_W     = 7;
  typedef logic [PTR_W-1:0] ptr_t;

  // Register byte offsets
  localparam logic [7:0] OFS_CONDITION = 8'h00;
  localparam logic [7:0] OFS_OWN_ADDR  = 8'h04;
  localparam logic [7:0] OFS_CONTROL   = 8'h08;
  localparam logic [7:0] OFS_TALLY     = 8'h0C;
  localparam logic [7:0] OFS_BUFFER    = 8'h10;

  // Condition codes
  localparam logic [7:0] ST_OWN_READ   = 8'hA8;
  localparam logic [7:0] ST_ARB_READ   = 8'hB0;
  localparam logic [7:0] ST_COUNT_ACK  = 8'hB8;
  localparam logic [7:0] ST_NACKED     = 8'hC0;
  localparam logic [7:0] ST_LAST_AA0   = 8'hC8;
  localparam logic [7:0] ST_NO_INFO    = 8'hF8;

  localparam logic [7:0] CONDITION_RST = ST_NO_INFO;
  localparam logic [7:0] OWN_ADDR_RST  = 8'h00;
  localparam logic [7:0] CONTROL_RST   = 8'h00;
  localparam logic [7:0] TALLY_RST     = 8'h00;
  localparam logic [6:0] GENERAL_CALL  = 7'h00;

  typedef struct packed {
    logic       ack_enable;
    logic       rsvd6;
    logic       begin_condition_request;
    logic       halt_condition_request;
    logic       event_flag;
    logic [1:0] rsvd;
    logic       mode;
  } control_t;

  typedef struct packed {
    logic [6:0] addr;
    logic       general_call_enable;
  } own_addr_t;

  typedef struct packed {
    logic       final_byte_nack;
    logic [6:0] byte_tally_field;
  } tally_t;

  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_ADDR     = 3'b001,
    S_ADDR_ACK = 3'b010,
    S_HOLD     = 3'b011,
    S_TX_BIT   = 3'b100,
    S_TX_ACK   = 3'b101
  } state_t;

endpackage : i2c_stx_pkg

// ---- tx_buffer_mem.sv ----
// Transmit byte buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module tx_buffer_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 68,
  parameter int unsigned AW    = 7
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("tx_buffer_mem: depth does not fit address width");
  end

  // No reset: contents are undefined until software loads them
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : tx_buffer_mem
`default_nettype wire

// ---- i2c_slave_tx_buffered.sv ----
// Buffered I2C slave transmitter with APB register access
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_tx_buffered #(
  parameter int unsigned BUF_DEPTH = i2c_stx_pkg::BUF_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  input  wire logic        arb_lost,
  output logic             int_n,
  output logic             start_launch,
  output logic             general_call_seen
);

  if (BUF_DEPTH < 2 || BUF_DEPTH > (1 << i2c_stx_pkg::PTR_W)) begin : g_bad_depth
    $error("i2c_slave_tx_buffered: BUF_DEPTH out of range");
  end

  localparam i2c_stx_pkg::ptr_t LAST_SLOT = i2c_stx_pkg::ptr_t'(BUF_DEPTH - 1);

  function automatic i2c_stx_pkg::ptr_t ptr_step(input i2c_stx_pkg::ptr_t p);
    ptr_step = (p == LAST_SLOT) ? '0 : p + 1'b1;
  endfunction : ptr_step

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  i2c_stx_pkg::state_t    state_r;
  i2c_stx_pkg::control_t  ctl_r;
  i2c_stx_pkg::control_t  ctl_wdata;
  i2c_stx_pkg::own_addr_t own_r;
  i2c_stx_pkg::tally_t    tally_r;
  i2c_stx_pkg::ptr_t      wr_ptr_r;
  i2c_stx_pkg::ptr_t      rd_ptr_r;

  logic [7:0]  status_r;
  logic [31:0] prdata_r;
  logic [1:0]  scl_sync_r;
  logic [1:0]  sda_sync_r;
  logic        scl_q_r;
  logic        sda_q_r;
  logic        scl_s;
  logic        sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic [2:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [6:0]  sent_r;
  logic [6:0]  sent_nxt;
  logic [6:0]  seq_len_r;
  logic        ack_phase_r;
  logic        ack_got_r;
  logic        arb_r;
  logic        busy_r;
  logic        start_pend_r;
  logic        start_launch_r;
  logic        gc_seen_r;
  logic        scl_oe_n_r;
  logic        sda_oe_n_r;
  logic [7:0]  mem_rdata;
  logic        apb_setup;
  logic        apb_wr;
  logic        addr_hit;
  logic        ctl_wr;
  logic        buf_we;
  logic        evt_set;
  logic [7:0]  evt_code;
  logic        own_match;
  logic        seq_done;

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data prepared in the setup cycle

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign addr_hit  = (paddr == i2c_stx_pkg::OFS_CONDITION) |
                     (paddr == i2c_stx_pkg::OFS_OWN_ADDR) |
                     (paddr == i2c_stx_pkg::OFS_CONTROL) |
                     (paddr == i2c_stx_pkg::OFS_TALLY) |
                     (paddr == i2c_stx_pkg::OFS_BUFFER);
  assign ctl_wr    = apb_wr & (paddr == i2c_stx_pkg::OFS_CONTROL);
  assign buf_we    = apb_wr & (paddr == i2c_stx_pkg::OFS_BUFFER);
  assign ctl_wdata = i2c_stx_pkg::control_t'(pwdata[7:0]);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_hit;
  assign prdata    = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      unique case (paddr)
        i2c_stx_pkg::OFS_CONDITION: prdata_r <= {24'h00_0000, status_r};
        i2c_stx_pkg::OFS_OWN_ADDR:  prdata_r <= {24'h00_0000, own_r};
        i2c_stx_pkg::OFS_CONTROL:   prdata_r <= {24'h00_0000, ctl_r};
        i2c_stx_pkg::OFS_TALLY:     prdata_r <= {24'h00_0000, tally_r};
        default:                    prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers written by software

  // Host loads these before any addressing can happen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_r <= i2c_stx_pkg::OWN_ADDR_RST;
    end else if (apb_wr && paddr == i2c_stx_pkg::OFS_OWN_ADDR) begin
      own_r <= i2c_stx_pkg::own_addr_t'(pwdata[7:0]);
    end
  end

  // Event flag: hardware set beats a clearing write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= i2c_stx_pkg::CONTROL_RST;
    end else begin
      if (ctl_wr) begin
        ctl_r.ack_enable              <= ctl_wdata.ack_enable;
        ctl_r.begin_condition_request <= ctl_wdata.begin_condition_request;
        ctl_r.halt_condition_request  <= ctl_wdata.halt_condition_request;
        ctl_r.mode                    <= ctl_wdata.mode;
      end
      if (evt_set) begin
        ctl_r.event_flag <= 1'b1;
      end else if (ctl_wr && !ctl_wdata.event_flag) begin
        ctl_r.event_flag <= 1'b0;
      end
    end
  end

  // Count in while idle, bytes sent out after each B8h, C0h or C8h event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tally_r <= i2c_stx_pkg::TALLY_RST;
    end else if (evt_set && state_r == i2c_stx_pkg::S_TX_ACK) begin
      tally_r.byte_tally_field <= sent_nxt;
    end else if (apb_wr && paddr == i2c_stx_pkg::OFS_TALLY) begin
      tally_r <= i2c_stx_pkg::tally_t'(pwdata[7:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= i2c_stx_pkg::CONDITION_RST;
    end else if (evt_set) begin
      status_r <= evt_code;
    end
  end

  // Fresh sequence refills from slot zero after every event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
    end else if (evt_set) begin
      wr_ptr_r <= '0;
    end else if (buf_we) begin
      wr_ptr_r <= ptr_step(wr_ptr_r);
    end
  end

  tx_buffer_mem #(
    .WIDTH (8),
    .DEPTH (BUF_DEPTH),
    .AW    (i2c_stx_pkg::PTR_W)
  ) u_buf (
    .clk   (pclk),
    .we    (buf_we),
    .waddr (wr_ptr_r),
    .wdata (pwdata[7:0]),
    .raddr (rd_ptr_r),
    .rdata (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus sampling and conditions

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_q_r    <= scl_s;
      sda_q_r    <= sda_s;
    end
  end

  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s & ~scl_q_r;
  assign scl_fall  = ~scl_s & scl_q_r;
  assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // Live bit: clearing it isolates the device, setting it rejoins
  assign own_match = (shift_r[6:0] == own_r.addr) & sda_s & ctl_r.ack_enable;
  assign sent_nxt  = sent_r + 7'h01;
  assign seq_done  = (sent_nxt >= seq_len_r);

  //////////////////////////////////////////////////////////////////////////////
  // Events raised toward the host

  always_comb begin
    evt_set  = 1'b0;
    evt_code = i2c_stx_pkg::ST_NO_INFO;
    if (state_r == i2c_stx_pkg::S_ADDR_ACK && scl_fall && ack_phase_r) begin
      evt_set  = 1'b1;
      evt_code = arb_r ? i2c_stx_pkg::ST_ARB_READ : i2c_stx_pkg::ST_OWN_READ;
    end else if (state_r == i2c_stx_pkg::S_TX_ACK && scl_fall) begin
      if (!ack_got_r) begin
        evt_set  = 1'b1;
        evt_code = i2c_stx_pkg::ST_NACKED;
      end else if (seq_done) begin
        evt_set  = 1'b1;
        evt_code = ctl_r.ack_enable ? i2c_stx_pkg::ST_COUNT_ACK : i2c_stx_pkg::ST_LAST_AA0;
      end
    end
  end

  assign int_n = ~ctl_r.event_flag;

  //////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= i2c_stx_pkg::S_IDLE;
      bit_cnt_r   <= 3'h0;
      shift_r     <= 8'h00;
      sent_r      <= 7'h00;
      seq_len_r   <= 7'h00;
      ack_phase_r <= 1'b0;
      ack_got_r   <= 1'b0;
      rd_ptr_r    <= '0;
    end else if (start_det) begin
      state_r   <= i2c_stx_pkg::S_ADDR;
      bit_cnt_r <= 3'h0;
    end else if (stop_det) begin
      state_r <= i2c_stx_pkg::S_IDLE;
    end else begin
      unique case (state_r)
        i2c_stx_pkg::S_IDLE: begin
          ack_phase_r <= 1'b0;
        end
        i2c_stx_pkg::S_ADDR: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              state_r     <= own_match ? i2c_stx_pkg::S_ADDR_ACK : i2c_stx_pkg::S_IDLE;
              ack_phase_r <= 1'b0;
            end
          end
        end
        i2c_stx_pkg::S_ADDR_ACK: begin
          if (scl_fall) begin
            if (!ack_phase_r) begin
              ack_phase_r <= 1'b1;
            end else begin
              state_r  <= i2c_stx_pkg::S_HOLD;
              rd_ptr_r <= '0;
            end
          end
        end
        i2c_stx_pkg::S_HOLD: begin
          // Leaves once the host has cleared the flag
          if (!ctl_r.event_flag) begin
            state_r   <= i2c_stx_pkg::S_TX_BIT;
            shift_r   <= mem_rdata;
            rd_ptr_r  <= ptr_step(rd_ptr_r);
            bit_cnt_r <= 3'h0;
            sent_r    <= 7'h00;
            seq_len_r <= tally_r.byte_tally_field;
          end
        end
        i2c_stx_pkg::S_TX_BIT: begin
          if (scl_fall) begin
            if (bit_cnt_r == 3'h7) begin
              state_r <= i2c_stx_pkg::S_TX_ACK;
            end else begin
              shift_r   <= {shift_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 3'h1;
            end
          end
        end
        i2c_stx_pkg::S_TX_ACK: begin
          if (scl_rise) begin
            ack_got_r <= ~sda_s;
          end
          if (scl_fall) begin
            sent_r <= sent_nxt;
            if (!ack_got_r) begin
              state_r <= i2c_stx_pkg::S_IDLE;
            end else if (seq_done) begin
              state_r  <= ctl_r.ack_enable ? i2c_stx_pkg::S_HOLD : i2c_stx_pkg::S_IDLE;
              rd_ptr_r <= '0;
            end else begin
              state_r   <= i2c_stx_pkg::S_TX_BIT;
              shift_r   <= mem_rdata;
              rd_ptr_r  <= ptr_step(rd_ptr_r);
              bit_cnt_r <= 3'h0;
            end
          end
        end
        default: begin
          state_r <= i2c_stx_pkg::S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Arbitration, bus busy, queued start, general call

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_r <= 1'b0;
    end else if (arb_lost) begin
      arb_r <= 1'b1;
    end else if (stop_det || evt_set) begin
      arb_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
    end else if (start_det) begin
      busy_r <= 1'b1;
    end else if (stop_det) begin
      busy_r <= 1'b0;
    end
  end

  // Launch is a request to the master engine, which makes the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pend_r   <= 1'b0;
      start_launch_r <= 1'b0;
    end else begin
      start_launch_r <= start_pend_r & ~busy_r;
      if (ctl_wr && ctl_wdata.begin_condition_request) begin
        start_pend_r <= 1'b1;
      end else if (!busy_r) begin
        start_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gc_seen_r <= 1'b0;
    end else begin
      gc_seen_r <= (state_r == i2c_stx_pkg::S_ADDR) & scl_rise & (bit_cnt_r == 3'h7) &
                   (shift_r[6:0] == i2c_stx_pkg::GENERAL_CALL) & ~sda_s &
                   own_r.general_call_enable;
    end
  end

  assign start_launch      = start_launch_r;
  assign general_call_seen = gc_seen_r;

  //////////////////////////////////////////////////////////////////////////////
  // Open-drain drivers: output value always low, enable active low

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
    end else begin
      scl_oe_n_r <= ~(state_r == i2c_stx_pkg::S_HOLD);
      // Released outside the addressed states, so a reader sees ones
      // First bit set up while the clock is still held, never with its release
      sda_oe_n_r <= ~(((state_r == i2c_stx_pkg::S_ADDR_ACK) & ack_phase_r) |
                      ((state_r == i2c_stx_pkg::S_HOLD) & ~ctl_r.event_flag & ~mem_rdata[7]) |
                      ((state_r == i2c_stx_pkg::S_TX_BIT) & ~shift_r[7]));
    end
  end

  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_n = scl_oe_n_r;
  assign sda_oe_n = sda_oe_n_r;

endmodule : i2c_slave_tx_buffered
`default_nettype wire

// ---- i2c_stx_sva.sv ----
// Port checker for the buffered I2C slave transmitter
`timescale 1ns/1ps
`default_nettype none
module i2c_stx_sva #(
  parameter int unsigned BUF_DEPTH = 68
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_n,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_n,
  input wire logic        arb_lost,
  input wire logic        int_n,
  input wire logic        start_launch,
  input wire logic        general_call_seen
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire clr_wr = psel && penable && pwrite && paddr == i2c_stx_pkg::OFS_CONTROL && !pwdata[3];
  ////////////////////////////////////////////////////////////////////////////
  chk_reset_idle:
    assert property ($rose(presetn) |-> int_n && scl_oe_n && sda_oe_n) else $error("outputs busy after reset");
  chk_open_drain:
    assert property (!scl_o && !sda_o) else $error("pin driven high");
  chk_sda_scl_low:
    assert property ($changed(sda_oe_n) |-> !scl_i) else $error("data moved while clock high");
  chk_stretch_cause:
    assert property ($fell(scl_oe_n) |-> !int_n) else $error("clock held with no event");
  chk_stretch_free:
    assert property ($rose(int_n) |-> ##[0:2] scl_oe_n) else $error("clock kept low after service");
  chk_event_hold:
    assert property (!int_n && !clr_wr |=> !int_n) else $error("interrupt dropped by itself");
  chk_event_clear:
    assert property (clr_wr && !int_n |=> int_n) else $error("interrupt not cleared");
  chk_launch_pulse:
    assert property (start_launch |=> !start_launch) else $error("start request longer than one cycle");
  chk_gc_pulse:
    assert property (general_call_seen |=> !general_call_seen) else $error("general call flag stuck");
endmodule : i2c_stx_sva
bind i2c_slave_tx_buffered i2c_stx_sva #(.BUF_DEPTH(BUF_DEPTH)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n), .arb_lost(arb_lost), .int_n(int_n), .start_launch(start_launch),
  .general_call_seen(general_call_seen));
`default_nettype wire

// ---- i2c_master_model.sv ----
// Behavioural I2C master receiver on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe_n,
  output logic      sda_oe_n
);
  localparam realtime Q = 31.25;
  logic [7:0] rx;
  event       got;
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One bit; a high level only releases, the pull-up makes the one
  task automatic bit_io(input logic d, output logic s);
    sda_oe_n = d;
    #Q scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    #Q s = sda;
    #Q scl_oe_n = 1'b0;
    #Q;
  endtask : bit_io
  // Whole frame: START, address, data bytes, STOP; clock idles high outside
  task automatic xfer(input logic [6:0] a, input logic rd, input int n, output logic ack_n);
    logic       s;
    logic [7:0] sh;
    sh = {a, rd};
    sda_oe_n = 1'b0;
    #(2*Q) scl_oe_n = 1'b0;
    #Q;
    for (int i = 7; i >= 0; i--) bit_io(sh[i], s);
    bit_io(1'b1, ack_n);
    for (int k = 0; k < n && rd && !ack_n; k++) begin
      for (int i = 7; i >= 0; i--) bit_io(1'b1, rx[i]);
      -> got;
      bit_io(k == n - 1, s);
    end
    sda_oe_n = 1'b0;
    #Q scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    #Q sda_oe_n = 1'b1;
    #(2*Q);
  endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the buffered I2C slave transmitter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arb_lost = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_data, res_val;
  logic        pready, pslverr, rd_err, scl_oe_n, sda_oe_n, m_scl_oe_n, m_sda_oe_n, scl_o, sda_o;
  logic        int_n, start_launch, general_call_seen, ack_n, launched = 1'b0;
  wire         scl = scl_oe_n & m_scl_oe_n;
  wire         sda = sda_oe_n & m_sda_oe_n;
  int          bad_count = 0, samples_checked = 0, gc_hits = 0, seed = 32'h8CCA0A76;
  logic [31:0] exp_q[$];
  logic [7:0]  slot [i2c_stx_pkg::BUF_DEPTH];
  logic [6:0]  own;
  event        res_ev;
  always #4 pclk = ~pclk;
  i2c_slave_tx_buffered dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .arb_lost(arb_lost),
    .int_n(int_n), .start_launch(start_launch), .general_call_seen(general_call_seen));
  i2c_master_model mst (.scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  always @(res_ev) chk("register", exp_q.pop_front(), res_val);
  always @(mst.got) chk("link byte", exp_q.pop_front(), {24'h0, mst.rx});
  always @(posedge pclk) begin
    if (general_call_seen === 1'b1) gc_hits++;
    if (start_launch === 1'b1) launched = 1'b1;
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
    res_val = rd_data;
    -> res_ev;
  endtask : rd
  // Interrupt low is the cue; a missing one counts against the run
  task automatic wait_int();
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 20000 && int_n !== 1'b0; i++) @(posedge pclk);
    if (int_n !== 1'b0) chk("int_n", 32'h0, {31'h0, int_n});
  endtask : wait_int
  task automatic serve(input logic [7:0] code, input logic [6:0] n, input int nw, input logic [7:0] ctl,
                       input logic ff);
    wait_int();
    rd(i2c_stx_pkg::OFS_CONDITION, {24'h0, code});
    if (ff) exp_q.push_back(32'h0000_00FF);
    if (nw > 0) apb(1'b1, i2c_stx_pkg::OFS_TALLY, {24'h0, 1'($random(seed)), n});
    for (int i = 0; i < nw; i++) begin
      slot[i % i2c_stx_pkg::BUF_DEPTH] = 8'($random(seed));
      apb(1'b1, i2c_stx_pkg::OFS_BUFFER, {24'h0, slot[i % i2c_stx_pkg::BUF_DEPTH]});
    end
    for (int i = 0; i < nw && i < n; i++) exp_q.push_back({24'h0, slot[i]});
    apb(1'b1, i2c_stx_pkg::OFS_CONTROL, {24'h0, ctl});
  endtask : serve
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    #400000;
    chk("watchdog", 32'h0, 32'h1);
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(i2c_stx_pkg::OFS_CONDITION, {24'h0, i2c_stx_pkg::CONDITION_RST});
    rd(i2c_stx_pkg::OFS_OWN_ADDR, {24'h0, i2c_stx_pkg::OWN_ADDR_RST});
    rd(i2c_stx_pkg::OFS_CONTROL, {24'h0, i2c_stx_pkg::CONTROL_RST});
    rd(i2c_stx_pkg::OFS_TALLY, {24'h0, i2c_stx_pkg::TALLY_RST});
    rd(8'h14, 32'h0);
    chk("slave error", 32'h1, {31'h0, rd_err});
    own = {1'b1, 6'($random(seed))};
    apb(1'b1, i2c_stx_pkg::OFS_OWN_ADDR, {24'h0, own, 1'b1});
    apb(1'b1, i2c_stx_pkg::OFS_CONTROL, 32'h0000_0081);
    fork
      mst.xfer(own, 1'b1, 6, ack_n);
      begin
        serve(i2c_stx_pkg::ST_OWN_READ, 7'd3, 3, 8'h81, 1'b0);
        serve(i2c_stx_pkg::ST_COUNT_ACK, 7'd2, 2, 8'h01, 1'b0);
        serve(i2c_stx_pkg::ST_LAST_AA0, 7'd0, 0, 8'h21, 1'b1);
      end
    join
    chk("address ack", 32'h0, {31'h0, ack_n});
    repeat (20) @(posedge pclk);
    chk("start launch", 32'h1, {31'h0, launched});
    mst.xfer(own, 1'b1, 1, ack_n);
    chk("ignored address", 32'h1, {31'h0, ack_n});
    mst.xfer(7'h00, 1'b0, 0, ack_n);
    chk("general call", 32'h1, gc_hits);
    apb(1'b1, i2c_stx_pkg::OFS_CONTROL, 32'h0000_0081);
    arb_lost <= 1'b1;
    @(posedge pclk);
    arb_lost <= 1'b0;
    fork
      mst.xfer(own, 1'b1, 1, ack_n);
      serve(i2c_stx_pkg::ST_ARB_READ, 7'd1, 69, 8'h81, 1'b0);
    join
    chk("address ack", 32'h0, {31'h0, ack_n});
    serve(i2c_stx_pkg::ST_NACKED, 7'd0, 0, 8'h81, 1'b0);
    fork
      mst.xfer(own, 1'b1, 1, ack_n);
      serve(i2c_stx_pkg::ST_OWN_READ, 7'd1, 1, 8'h81, 1'b0);
    join
    chk("address ack", 32'h0, {31'h0, ack_n});
    serve(i2c_stx_pkg::ST_NACKED, 7'd0, 0, 8'h81, 1'b0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
